// ---- core/spi_port_pkg.sv ----
package spi_port_pkg;

	// ***************************************************************
	// Configuration, flags, pins and transfer state
	// ***************************************************************
	typedef struct packed {
		logic       irq_enable_bit;
		logic       port_enable_bit;
		logic       open_drain_bit;
		logic       master_select_bit;
		logic       clock_polarity_bit;
		logic       clock_phase_bit;
		logic       lsb_first_bit;
		logic       size_bit;
		logic [7:0] sck_divider;
	} port_cfg_s;

	typedef struct packed {
		logic xfer_done_flag;
		logic write_clash_flag;
		logic multi_master_fault_flag;
	} port_flag_s;

	typedef struct packed {
		logic miso;
		logic mosi;
		logic sck;
		logic ss;
	} spi_pins_s;

	typedef enum logic {
		ST_IDLE,
		ST_RUN
	} xfer_state_e;

	// ***************************************************************
	// Constants
	// ***************************************************************
	localparam port_cfg_s  CFG_RESET      = 16'h0004;
	localparam port_flag_s FLAG_RESET     = 3'h0;
	localparam logic [3:0] DIR_RESET      = 4'h0;
	localparam logic [3:0] FAULT_DIR_KEEP = 4'h1;
	localparam logic [7:0] DIV_MIN        = 8'h02;
	localparam logic [5:0] EDGES_BYTE     = 6'h10;
	localparam logic [5:0] EDGES_WORD     = 6'h20;

endpackage

// ---- core/sck_rate_gen.sv ----
`timescale 1ns/10ps
`default_nettype none

module sck_rate_gen
	import spi_port_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// Control
	input  wire logic       run,
	input  wire logic [7:0] divider,
	// Half-period strobe
	output logic            tick
);

	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic       tick_reg;
	logic       tick_next;

	always_comb begin
		count_next = 8'h00;
		tick_next  = 1'b0;
		if (run && divider >= DIV_MIN) begin
			if (count_reg >= divider - 8'h01) begin
				tick_next = 1'b1;
			end else begin
				count_next = count_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= 8'h00;
			tick_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg  <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule

`default_nettype wire

// ---- core/spi_port.sv ----
`timescale 1ns/10ps
`default_nettype none

module spi_port
	import spi_port_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// Configuration and direction writes
	input  wire logic       cfg_wr,
	input  wire port_cfg_s  cfg_wdata,
	input  wire logic       dir_wr,
	input  wire logic [3:0] dir_wdata,
	// Status and data accesses
	input  wire logic       status_rd,
	input  wire logic       data_rd,
	input  wire logic       data_wr,
	input  wire logic [15:0] data_wdata,
	input  wire logic [3:0] gpio_out,
	// Readback
	output port_cfg_s       port_config,
	output port_flag_s      port_flags,
	output logic [15:0]     rx_data,
	output logic [3:0]      pin_direction,
	output logic [3:0]      pin_state_port,
	output logic            irq,
	// Pins
	input  wire spi_pins_s  pin_in,
	output spi_pins_s       pin_out,
	output spi_pins_s       pin_oe
);

	// ***************************************************************
	// Helpers
	// ***************************************************************
	function automatic logic top_bit(input logic [15:0] sh, input logic lsb,
		input logic wide);
		if (lsb) begin
			return sh[0];
		end
		return wide ? sh[15] : sh[7];
	endfunction

	function automatic logic [15:0] shift_in(input logic [15:0] sh, input logic b,
		input logic lsb, input logic wide);
		if (lsb) begin
			return wide ? {b, sh[15:1]} : {8'h00, b, sh[7:1]};
		end
		return {sh[14:0], b};
	endfunction

	// ***************************************************************
	// State
	// ***************************************************************
	port_cfg_s   port_config_reg, port_config_next;
	port_flag_s  port_flag_reg, port_flag_next;
	xfer_state_e state_reg, state_next;
	logic [5:0]  edge_cnt_reg, edge_cnt_next;
	logic [15:0] shift_data_reg, shift_data_next;
	logic [15:0] rx_data_reg, rx_data_next;
	logic [3:0]  pin_direction_reg, pin_direction_next;
	logic        out_bit_reg, out_bit_next;
	logic        sck_reg, sck_next;
	logic        armed_done_reg, armed_done_next;
	logic        armed_clash_reg, armed_clash_next;
	logic        armed_fault_reg, armed_fault_next;
	logic        irq_reg, irq_next;
	spi_pins_s   pin_out_reg, pin_out_next;
	spi_pins_s   pin_oe_reg, pin_oe_next;
	spi_pins_s   sync1_reg, sync2_reg;
	logic        sck_last_reg, ss_last_reg;

	logic        tick;
	logic        is_master, enabled, ss_low, sck_edge, ss_fall;
	logic        busy, edge_evt, sample, done_evt, acc_clr;
	logic [5:0]  last_edge, edge_idx;
	logic        in_bit;
	spi_pins_s   func_val, func_drv, val;

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_reg    <= 4'h1;
			sync2_reg    <= 4'h1;
			sck_last_reg <= 1'b0;
			ss_last_reg  <= 1'b1;
		end else begin
			sync1_reg    <= pin_in;
			sync2_reg    <= sync1_reg;
			sck_last_reg <= sync2_reg.sck;
			ss_last_reg  <= sync2_reg.ss;
		end
	end

	// The divider only runs for an active master transfer.
	sck_rate_gen u_rate (
		.core_clk (core_clk),
		.resetn   (resetn),
		.run      (is_master && enabled && state_reg == ST_RUN),
		.divider  (port_config_reg.sck_divider),
		.tick     (tick)
	);

	// ***************************************************************
	// Transfer engine
	// ***************************************************************
	always_comb begin
		is_master = port_config_reg.master_select_bit;
		enabled   = port_config_reg.port_enable_bit;
		ss_low    = !sync2_reg.ss;
		sck_edge  = sync2_reg.sck ^ sck_last_reg;
		ss_fall   = ss_last_reg && !sync2_reg.ss;
		last_edge = port_config_reg.size_bit ? EDGES_WORD : EDGES_BYTE;
		in_bit    = is_master ? sync2_reg.miso : sync2_reg.mosi;
		// A phase 1 slave start is always edge one, whatever the last frame left behind.
		edge_idx  = (state_reg == ST_IDLE) ? 6'h01 : edge_cnt_reg + 6'h01;
		if (is_master) begin
			busy = state_reg == ST_RUN;
		end else if (!port_config_reg.clock_phase_bit) begin
			busy = enabled && ss_low;
		end else begin
			busy = state_reg == ST_RUN;
		end

		state_next      = state_reg;
		edge_cnt_next   = edge_cnt_reg;
		shift_data_next = shift_data_reg;
		out_bit_next    = out_bit_reg;
		sck_next        = sck_reg;
		edge_evt        = 1'b0;
		done_evt        = 1'b0;

		if (state_reg == ST_IDLE) begin
			sck_next = port_config_reg.clock_polarity_bit;
			if (data_wr && !busy) begin
				shift_data_next = data_wdata;
				out_bit_next    = top_bit(data_wdata, port_config_reg.lsb_first_bit,
					port_config_reg.size_bit);
				if (is_master && enabled) begin
					state_next    = ST_RUN;
					edge_cnt_next = 6'h00;
				end
			end
			if (enabled && !is_master) begin
				if (!port_config_reg.clock_phase_bit && ss_fall) begin
					state_next    = ST_RUN;
					edge_cnt_next = 6'h00;
					out_bit_next  = top_bit(shift_data_reg,
						port_config_reg.lsb_first_bit, port_config_reg.size_bit);
				end else if (port_config_reg.clock_phase_bit && ss_low
					&& sck_edge) begin
					state_next = ST_RUN;
					edge_evt   = 1'b1;
				end
			end
		end else if (!enabled || (!is_master && !ss_low)) begin
			state_next = ST_IDLE;
		end else if (is_master) begin
			if (tick && edge_cnt_reg < last_edge) begin
				sck_next = !sck_reg;
				edge_evt = 1'b1;
			end else if (tick) begin
				done_evt = 1'b1;
			end
		end else begin
			edge_evt = sck_edge;
		end

		// Phase 0 samples on odd edges, phase 1 on even edges.
		sample = port_config_reg.clock_phase_bit ? !edge_idx[0] : edge_idx[0];
		if (edge_evt) begin
			edge_cnt_next = edge_idx;
			if (sample) begin
				shift_data_next = shift_in(shift_data_reg, in_bit,
					port_config_reg.lsb_first_bit, port_config_reg.size_bit);
			end else if (edge_idx < last_edge) begin
				out_bit_next = top_bit(shift_data_reg,
					port_config_reg.lsb_first_bit, port_config_reg.size_bit);
			end
			if (edge_idx == last_edge) begin
				if (!is_master || !port_config_reg.clock_phase_bit) begin
					done_evt = 1'b1;
				end
			end
		end
		if (done_evt) begin
			state_next = ST_IDLE;
		end
	end

	// ***************************************************************
	// Flags, configuration and direction
	// ***************************************************************
	always_comb begin
		acc_clr = data_rd || (data_wr && !busy);
		port_flag_next     = port_flag_reg;
		port_config_next   = port_config_reg;
		pin_direction_next = pin_direction_reg;
		armed_done_next    = armed_done_reg;
		armed_clash_next   = armed_clash_reg;
		armed_fault_next   = armed_fault_reg;
		rx_data_next       = rx_data_reg;

		if (status_rd) begin
			armed_done_next  = port_flag_reg.xfer_done_flag;
			armed_clash_next = port_flag_reg.write_clash_flag;
			armed_fault_next = port_flag_reg.multi_master_fault_flag;
		end else if (acc_clr) begin
			armed_done_next  = 1'b0;
			armed_clash_next = 1'b0;
		end
		if (acc_clr && (armed_done_reg || armed_clash_reg)) begin
			port_flag_next.xfer_done_flag = 1'b0;
		end
		if (acc_clr && armed_clash_reg) begin
			port_flag_next.write_clash_flag = 1'b0;
		end
		// A late write still collides even inside the clearing sequence.
		if (data_wr && busy) begin
			port_flag_next.write_clash_flag = 1'b1;
		end
		if (done_evt) begin
			port_flag_next.xfer_done_flag = 1'b1;
			// An unread word is kept; the newer one is lost on overrun.
			if (!port_flag_reg.xfer_done_flag || acc_clr) begin
				rx_data_next = port_config_reg.size_bit ? shift_data_next
					: {8'h00, shift_data_next[7:0]};
			end
		end

		if (dir_wr) begin
			pin_direction_next = dir_wdata;
		end
		if (cfg_wr) begin
			port_config_next = cfg_wdata;
			armed_fault_next = 1'b0;
			if (armed_fault_reg) begin
				port_flag_next.multi_master_fault_flag = 1'b0;
			end else if (port_flag_reg.multi_master_fault_flag) begin
				port_config_next.master_select_bit = 1'b0;
				port_config_next.port_enable_bit   = 1'b0;
			end
		end
		if (is_master && enabled && ss_low) begin
			port_flag_next.multi_master_fault_flag = 1'b1;
			port_config_next.master_select_bit     = 1'b0;
			port_config_next.port_enable_bit       = 1'b0;
			pin_direction_next = pin_direction_next & FAULT_DIR_KEEP;
		end
		// The collision flag is deliberately left out of the request.
		irq_next = port_config_reg.irq_enable_bit
			&& (port_flag_reg.xfer_done_flag
			|| port_flag_reg.multi_master_fault_flag);
	end

	// ***************************************************************
	// Pin drivers
	// ***************************************************************
	always_comb begin
		func_val = 4'h0;
		func_drv = 4'h0;
		if (is_master) begin
			func_val.sck  = sck_reg;
			func_val.mosi = out_bit_reg;
			func_drv.sck  = 1'b1;
			func_drv.mosi = 1'b1;
		end else begin
			func_val.miso = out_bit_reg;
			func_drv.miso = 1'b1;
		end
		val          = enabled ? ((func_val & func_drv) | (gpio_out & ~func_drv))
			: gpio_out;
		pin_oe_next  = pin_direction_reg;
		if (enabled && !is_master && !ss_low) begin
			pin_oe_next.miso = 1'b0;
		end
		// Open-drain pins only ever pull low and rely on a pull-up.
		if (port_config_reg.open_drain_bit) begin
			pin_oe_next  = pin_oe_next & ~val;
			pin_out_next = 4'h0;
		end else begin
			pin_out_next = val;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			port_config_reg   <= CFG_RESET;
			port_flag_reg     <= FLAG_RESET;
			state_reg         <= ST_IDLE;
			edge_cnt_reg      <= 6'h00;
			shift_data_reg    <= 16'h0000;
			rx_data_reg       <= 16'h0000;
			pin_direction_reg <= DIR_RESET;
			out_bit_reg       <= 1'b0;
			sck_reg           <= 1'b0;
			armed_done_reg    <= 1'b0;
			armed_clash_reg   <= 1'b0;
			armed_fault_reg   <= 1'b0;
			irq_reg           <= 1'b0;
			pin_out_reg       <= 4'h0;
			pin_oe_reg        <= 4'h0;
		end else begin
			port_config_reg   <= port_config_next;
			port_flag_reg     <= port_flag_next;
			state_reg         <= state_next;
			edge_cnt_reg      <= edge_cnt_next;
			shift_data_reg    <= shift_data_next;
			rx_data_reg       <= rx_data_next;
			pin_direction_reg <= pin_direction_next;
			out_bit_reg       <= out_bit_next;
			sck_reg           <= sck_next;
			armed_done_reg    <= armed_done_next;
			armed_clash_reg   <= armed_clash_next;
			armed_fault_reg   <= armed_fault_next;
			irq_reg           <= irq_next;
			pin_out_reg       <= pin_out_next;
			pin_oe_reg        <= pin_oe_next;
		end
	end

	assign port_config    = port_config_reg;
	assign port_flags     = port_flag_reg;
	assign rx_data        = rx_data_reg;
	assign pin_direction  = pin_direction_reg;
	assign pin_state_port = sync2_reg;
	assign irq            = irq_reg;
	assign pin_out        = pin_out_reg;
	assign pin_oe         = pin_oe_reg;

endmodule

`default_nettype wire

// ---- tb/spi_port_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****
// Flag, pin and clock checks
// ****
module spi_port_monitor
	import spi_port_pkg::*;
(
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       resetn,
	// Software side
	input wire logic       cfg_wr,
	input wire logic       data_rd,
	input wire logic       data_wr,
	input wire port_cfg_s  port_config,
	input wire port_flag_s port_flags,
	input wire logic [3:0] pin_direction,
	input wire logic       irq,
	// Pins
	input wire spi_pins_s  pin_out
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_fault_rise;
		$rose(port_flags.multi_master_fault_flag);
	endsequence
	sequence s_sck_hold;
		$stable(pin_out.sck) [*3];
	endsequence

	a_irq_level: assert property (
		irq == $past(port_config.irq_enable_bit
		&& (port_flags.xfer_done_flag || port_flags.multi_master_fault_flag)))
		else $error("irq does not follow flags");
	a_sck_rate: assert property (
		$changed(pin_out.sck) && port_config.master_select_bit
		&& port_config.sck_divider == 8'h04 |=> s_sck_hold)
		else $error("sck half period wrong");
	a_fault_cause: assert property (
		s_fault_rise |-> $past(port_config.master_select_bit && port_config.port_enable_bit))
		else $error("fault without master");
	a_fault_drops: assert property (
		s_fault_rise |-> !port_config.master_select_bit && !port_config.port_enable_bit
		&& pin_direction[3:1] == 3'h0)
		else $error("fault did not disable port");
	a_fault_blocks: assert property (
		port_flags.multi_master_fault_flag |-> !port_config.port_enable_bit
		&& !port_config.master_select_bit)
		else $error("enable set while fault");
	a_fault_clear: assert property (
		$fell(port_flags.multi_master_fault_flag) |-> $past(cfg_wr))
		else $error("fault cleared without config write");
	a_clash_cause: assert property (
		$rose(port_flags.write_clash_flag) |-> $past(data_wr))
		else $error("clash without data write");
	a_done_clear: assert property (
		$fell(port_flags.xfer_done_flag) |-> $past(data_rd || data_wr))
		else $error("done cleared without data access");
	a_open_drain: assert property (
		port_config.open_drain_bit [*2] |-> pin_out == '0)
		else $error("open drain pin driven high");
endmodule

bind spi_port spi_port_monitor u_monitor (
	.core_clk, .resetn, .cfg_wr, .data_rd, .data_wr, .port_config,
	.port_flags, .pin_direction, .irq, .pin_out
);

`default_nettype wire

// ---- tb/spi_far_slave.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****
// External slave, phase 0, idle-low clock, MSB first
// ****
module spi_far_slave (
	// Bus lines
	input wire logic        sel_n,
	input wire logic        sck,
	input wire logic        mosi,
	// Word sent and word received
	input wire logic [15:0] tx_word,
	output logic            miso,
	output logic [15:0]     rx_word
);
	logic [15:0] sh;

	initial begin
		miso = 1'b0;
		rx_word = '0;
		sh = '0;
	end
	// First bit is on the line before the first edge.
	always @(negedge sel_n) begin
		sh = tx_word;
		rx_word = '0;
		miso = tx_word[15];
	end
	// Released line has no pull-up, so it does not keep the last bit.
	always @(posedge sel_n) begin
		miso = ~miso;
	end
	always @(posedge sck) begin
		if (!sel_n) rx_word = {rx_word[14:0], mosi};
	end
	always @(negedge sck) begin
		if (!sel_n) begin
			sh = sh << 1;
			miso = sh[15];
		end
	end
endmodule

`default_nettype wire

// ---- tb/spi_port_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****
// Bench
// ****
module spi_port_tb
	import spi_port_pkg::*;
;
	localparam int K_CFG = 0, K_DIR = 1, K_STAT = 2, K_RD = 3, K_WR = 4;
	logic core_clk = 1'b0, resetn = 1'b0;
	logic cfg_wr = 1'b0, dir_wr = 1'b0, status_rd = 1'b0, data_rd = 1'b0, data_wr = 1'b0;
	port_cfg_s cfg_wdata = '0, port_config;
	logic [3:0] dir_wdata = '0, pin_direction, pin_state_port;
	logic [15:0] data_wdata = '0, rx_data, far_tx = '0, far_rx;
	port_flag_s port_flags;
	spi_pins_s pin_in, pin_out, pin_oe;
	logic irq, far_miso, sel_n = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss_n = 1'b1;
	logic [7:0] seen_miso;
	int n_fail = 0, cmp_count = 0;
	logic [15:0] m_cfg[2] = '{16'hd004, 16'hd304};
	logic [15:0] m_tx[2] = '{16'h00a5, 16'h1234};
	logic [15:0] m_far[2] = '{16'h3c00, 16'hc0de};
	logic [15:0] m_rx[2] = '{16'h003c, 16'h7b03};
	logic [15:0] m_frx[2] = '{16'h00a5, 16'h2c48};
	logic [15:0] s1_tx[2] = '{16'h00c3, 16'h0071};
	logic [7:0] s1_in[2] = '{8'h2d, 8'he4};
	logic [7:0] p0_in = 8'h5a;

	always #12.5 core_clk = ~core_clk;
	assign pin_in = {pin_oe.miso ? pin_out.miso : far_miso,
		pin_oe.mosi ? pin_out.mosi : tb_mosi,
		pin_oe.sck ? pin_out.sck : tb_sck,
		pin_oe.ss ? pin_out.ss : tb_ss_n};

	spi_port DUT (.core_clk(core_clk), .resetn(resetn), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .dir_wr(dir_wr), .dir_wdata(dir_wdata),
		.status_rd(status_rd), .data_rd(data_rd), .data_wr(data_wr),
		.data_wdata(data_wdata), .gpio_out(4'h0), .port_config(port_config),
		.port_flags(port_flags), .rx_data(rx_data), .pin_direction(pin_direction),
		.pin_state_port(pin_state_port), .irq(irq), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe));
	spi_far_slave far (.sel_n(sel_n), .sck(pin_out.sck), .mosi(pin_out.mosi),
		.tx_word(far_tx), .miso(far_miso), .rx_word(far_rx));

	task end_sim;
		$display("mismatches %0d comparisons %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One access pulse; the pulse is dropped an edge later, so calls never collide.
	task acc(input int k, input logic [15:0] v);
		@(posedge core_clk);
		cfg_wr <= (k == K_CFG);
		dir_wr <= (k == K_DIR);
		status_rd <= (k == K_STAT);
		data_rd <= (k == K_RD);
		data_wr <= (k == K_WR);
		cfg_wdata <= port_cfg_s'(v);
		dir_wdata <= v[3:0];
		data_wdata <= v;
		@(posedge core_clk);
		{cfg_wr, dir_wr, status_rd, data_rd, data_wr} <= 5'h00;
	endtask

	task wait_done;
		int i;
		for (i = 0; i < 3000 && port_flags.xfer_done_flag !== 1'b1; i++) @(posedge core_clk);
		if (i == 3000) begin
			n_fail++;
			$display("CHECK FAILED done wait expected 1 seen timeout");
			end_sim;
		end
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		check("config", port_config, CFG_RESET);
		check("flags", port_flags, FLAG_RESET);
		check("oe", pin_oe, 4'h0);
		// Master: byte MSB first, then word LSB first, each with a clashing write.
		acc(K_DIR, 16'h0006);
		for (int c = 0; c < 2; c++) begin
			acc(K_CFG, m_cfg[c]);
			far_tx <= m_far[c];
			sel_n <= 1'b0;
			acc(K_WR, m_tx[c]);
			acc(K_WR, 16'hffff);
			wait_done;
			@(posedge core_clk);
			check("rx", rx_data, m_rx[c]);
			check("far rx", far_rx, m_frx[c]);
			check("flags", port_flags, 3'b110);
			check("irq", irq, 1'b1);
			sel_n <= 1'b1;
			acc(K_STAT, 16'h0000);
			acc(K_RD, 16'h0000);
			@(posedge core_clk);
			check("cleared", port_flags, 3'b000);
		end
		// Mode fault: select pulled low while master.
		acc(K_DIR, 16'h000e);
		acc(K_CFG, 16'h7004);
		tb_ss_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		check("fault", port_flags, 3'b001);
		check("cfg", port_config[14:12], 3'b010);
		check("dir", pin_direction, 4'h0);
		check("ss pin", pin_state_port[0], 1'b0);
		tb_ss_n <= 1'b1;
		acc(K_CFG, 16'h5004);
		@(posedge core_clk);
		check("blocked", port_config[14:12], 3'b000);
		acc(K_STAT, 16'h0000);
		acc(K_CFG, 16'h5004);
		@(posedge core_clk);
		check("fault clr", port_flags, 3'b000);
		check("restored", port_config[14:12], 3'b101);
		// Divider 1 stops the master clock, so the written word never leaves.
		acc(K_CFG, 16'h5001);
		acc(K_WR, 16'h0055);
		repeat (40) @(posedge core_clk);
		check("stalled sck", pin_out.sck, 1'b0);
		check("stalled flags", port_flags, 3'b000);
		// Slave, phase 0, divider 0 (unused in slave mode).
		acc(K_CFG, 16'h4000);
		acc(K_DIR, 16'h0008);
		acc(K_WR, 16'h0096);
		tb_ss_n <= 1'b0;
		// Select needs two synchroniser edges before the port counts it as low.
		repeat (3) @(posedge core_clk);
		acc(K_WR, 16'h00ff);
		repeat (6) @(posedge core_clk);
		for (int i = 7; i >= 0; i--) begin
			tb_mosi <= p0_in[i];
			repeat (8) @(posedge core_clk);
			seen_miso[i] = pin_out.miso;
			tb_sck <= 1'b1;
			repeat (8) @(posedge core_clk);
			tb_sck <= 1'b0;
		end
		repeat (8) @(posedge core_clk);
		tb_ss_n <= 1'b1;
		tb_mosi <= ~tb_mosi;
		repeat (8) @(posedge core_clk);
		check("slave rx", rx_data, 16'h005a);
		check("slave miso", seen_miso, 8'h96);
		check("slave flags", port_flags, 3'b110);
		// Slave, phase 1, idle-high clock, select left low across both bytes.
		acc(K_STAT, 16'h0000);
		acc(K_RD, 16'h0000);
		acc(K_CFG, 16'h4c00);
		tb_sck <= 1'b1;
		for (int b = 0; b < 2; b++) begin
			acc(K_WR, s1_tx[b]);
			tb_ss_n <= 1'b0;
			repeat (6) @(posedge core_clk);
			for (int i = 7; i >= 0; i--) begin
				tb_sck <= 1'b0;
				tb_mosi <= s1_in[b][i];
				if (i == 4) begin
					acc(K_WR, 16'h00ff);
				end
				repeat ((i == 4) ? 6 : 8) @(posedge core_clk);
				seen_miso[i] = pin_out.miso;
				tb_sck <= 1'b1;
				repeat (8) @(posedge core_clk);
			end
			repeat (8) @(posedge core_clk);
			check("p1 rx", rx_data, {8'h00, s1_in[b]});
			check("p1 miso", seen_miso, s1_tx[b][7:0]);
			check("p1 flags", port_flags, 3'b110);
			acc(K_STAT, 16'h0000);
			acc(K_RD, 16'h0000);
			@(posedge core_clk);
			check("p1 cleared", port_flags, 3'b000);
		end
		tb_ss_n <= 1'b1;
		end_sim;
	end
endmodule

`default_nettype wire
